/* rtl/sbst_pkg.sv */
/*
 * Shared constants and types for the boundary-scan test access port of the burst SRAM.
 * Assumes the test controller drives the scan clock, mode select and serial input.
 */
package sbst_pkg;

    localparam int SBST_IR_LEN = 3;
    localparam int SBST_ID_LEN = 32;
    localparam int SBST_CHAIN_NARROW = 51;
    localparam int SBST_CHAIN_WIDE = 70;

    localparam logic [2:0] SBST_OP_CAPTURE_HIZ = 3'h0;
    localparam logic [2:0] SBST_OP_IDENT = 3'h1;
    localparam logic [2:0] SBST_OP_SAMPLE_HIZ = 3'h2;
    localparam logic [2:0] SBST_OP_SAMPLE = 3'h4;
    localparam logic [2:0] SBST_OP_BYPASS = 3'h7;
    localparam logic [2:0] SBST_IR_RESET = SBST_OP_IDENT;
    localparam logic [2:0] SBST_IR_CAPTURE = 3'h1;

    // Identification code field positions.
    localparam int SBST_ID_REV_LSB = 28;
    localparam int SBST_ID_DEPTH_LSB = 23;
    localparam int SBST_ID_WIDTH_LSB = 18;
    localparam int SBST_ID_RSVD_LSB = 12;
    localparam int SBST_ID_MANUF_LSB = 1;
    localparam logic [4:0] SBST_DEPTH_512K = 5'h07;
    localparam logic [4:0] SBST_DEPTH_1M = 5'h08;
    localparam logic [4:0] SBST_WIDTH_X36 = 5'h04;
    localparam logic [4:0] SBST_WIDTH_X18 = 5'h03;
    localparam logic [5:0] SBST_ID_RSVD_VAL = 6'h00;
    localparam logic SBST_ID_PRESENT = 1'h1;
    localparam logic SBST_BYPASS_CAPTURE = 1'h0;

    typedef enum logic [15:0] {
        SBST_TLR = 16'h0001,
        SBST_RTI = 16'h0002,
        SBST_SEL_DR = 16'h0004,
        SBST_CAP_DR = 16'h0008,
        SBST_SH_DR = 16'h0010,
        SBST_EX1_DR = 16'h0020,
        SBST_PA_DR = 16'h0040,
        SBST_EX2_DR = 16'h0080,
        SBST_UP_DR = 16'h0100,
        SBST_SEL_IR = 16'h0200,
        SBST_CAP_IR = 16'h0400,
        SBST_SH_IR = 16'h0800,
        SBST_EX1_IR = 16'h1000,
        SBST_PA_IR = 16'h2000,
        SBST_EX2_IR = 16'h4000,
        SBST_UP_IR = 16'h8000
    } sbst_state_e;

    typedef struct packed {
        logic mode_sel;
        logic ser_in;
    } sbst_scan_in_s;

    typedef struct packed {
        logic ser_out;
        logic ser_out_oe;
    } sbst_scan_out_s;

endpackage

/* rtl/sbst_tap.sv */
/*
 * Boundary-scan test access port of the burst SRAM: state machine, instruction register,
 * identification, bypass and boundary registers, and the output-isolation control.
 * Assumes the scan clock is at most 10 MHz and the SRAM pin ring arrives asynchronously.
 */
// Behaviour
// R1: Code 000 captures pin ring, selects boundary chain, isolates SRAM outputs.
// R2: Code 001 loads the 32-bit identification code and selects it.
// R3: Identification and bypass leave SRAM operation untouched.
// R4: Code 010 selects boundary chain, captures pins, isolates SRAM outputs.
// R5: Code 100 captures pins into boundary chain, no preload, SRAM undisturbed.
// R6: Code 111 selects a single-bit bypass register.
// R7: Controller must not load codes 011, 101 or 110.
// R8: Instruction register is 3 bits; chain is 51 or 70 cells.
// R9: Identification bit 0 always reads 1.
// R10: Identification bits 27:23 give memory depth per organisation.
// R11: Identification bits 22:18 give data width per organisation.
// R12: Bits 31:28 carry revision; bits 17:12 are reserved.
// R13: Bits 11:1 hold an eleven-bit manufacturer code.
// R14: Mode select is sampled on the scan clock rising edge.
// R15: Serial input is sampled on the scan clock rising edge.
// R16: Serial output changes on the scan clock falling edge.
// R17: Controller keeps the scan clock at or below 10 MHz.
// R18: Identification is selected at power-up and in test-logic-reset.
// R19: Instruction shifts in Shift-IR and takes effect at Update-IR.
// R20: Boundary chain MSB faces serial input, LSB faces serial output.
// R21: Update-DR during sampling changes nothing.
// R22: Chain cells follow fixed pin order, lowest address bits last.
// R23: Bypass register captures zero in Capture-DR.
`timescale 1ns/1ps
module sbst_tap
    import sbst_pkg::*;
#(
    parameter bit WIDE_ORG = 1'b1,
    parameter logic [3:0] REVISION = 4'h0,
    // Arbitrary neutral manufacturer value.
    parameter logic [10:0] MANUF_CODE = 11'h155,
    parameter int CHAIN_LEN = WIDE_ORG ? SBST_CHAIN_WIDE : SBST_CHAIN_NARROW
) (
    // System side.
    input wire logic clk_sys,
    input wire logic srst,
    output logic sram_out_hiz,
    // Scan link.
    input wire logic tck,
    input wire sbst_scan_in_s scan_in,
    output sbst_scan_out_s scan_out,
    // Pin ring, cell 1 at bit 0.
    input wire logic [CHAIN_LEN-1:0] ring_pins
);

    if (CHAIN_LEN != (WIDE_ORG ? SBST_CHAIN_WIDE : SBST_CHAIN_NARROW)) begin : g_chk
        $error("Chain length does not match the organisation.");
    end

    // Power-up reset carried into the scan clock domain.
    logic rst_meta_reg;
    logic tap_rst;
    always_ff @(posedge tck) begin
        rst_meta_reg <= srst;
        tap_rst <= rst_meta_reg;
    end

    // Pin ring passes two flip-flops; a mid-transition capture is only ever a wrong value.
    logic [CHAIN_LEN-1:0] ring_meta_reg;
    logic [CHAIN_LEN-1:0] ring_sync_reg;
    always_ff @(posedge tck) begin
        ring_meta_reg <= ring_pins;
        ring_sync_reg <= ring_meta_reg;
    end

    function automatic sbst_state_e tap_step(input sbst_state_e s, input logic m);
        case (s)
            SBST_TLR: tap_step = m ? SBST_TLR : SBST_RTI;
            SBST_RTI: tap_step = m ? SBST_SEL_DR : SBST_RTI;
            SBST_SEL_DR: tap_step = m ? SBST_SEL_IR : SBST_CAP_DR;
            SBST_CAP_DR: tap_step = m ? SBST_EX1_DR : SBST_SH_DR;
            SBST_SH_DR: tap_step = m ? SBST_EX1_DR : SBST_SH_DR;
            SBST_EX1_DR: tap_step = m ? SBST_UP_DR : SBST_PA_DR;
            SBST_PA_DR: tap_step = m ? SBST_EX2_DR : SBST_PA_DR;
            SBST_EX2_DR: tap_step = m ? SBST_UP_DR : SBST_SH_DR;
            SBST_UP_DR: tap_step = m ? SBST_SEL_DR : SBST_RTI;
            SBST_SEL_IR: tap_step = m ? SBST_TLR : SBST_CAP_IR;
            SBST_CAP_IR: tap_step = m ? SBST_EX1_IR : SBST_SH_IR;
            SBST_SH_IR: tap_step = m ? SBST_EX1_IR : SBST_SH_IR;
            SBST_EX1_IR: tap_step = m ? SBST_UP_IR : SBST_PA_IR;
            SBST_PA_IR: tap_step = m ? SBST_EX2_IR : SBST_PA_IR;
            SBST_EX2_IR: tap_step = m ? SBST_UP_IR : SBST_SH_IR;
            SBST_UP_IR: tap_step = m ? SBST_SEL_DR : SBST_RTI;
            default: tap_step = SBST_TLR;
        endcase
    endfunction

    sbst_state_e state_reg;
    sbst_state_e state_next;
    assign state_next = tap_step(state_reg, scan_in.mode_sel);

    always_ff @(posedge tck) begin
        if (tap_rst) begin
            state_reg <= SBST_TLR;
        end else begin
            state_reg <= state_next; // R14
        end
    end

    // Identification code assembled from its fields.
    wire [4:0] id_depth = WIDE_ORG ? SBST_DEPTH_512K : SBST_DEPTH_1M; // R10
    wire [4:0] id_width = WIDE_ORG ? SBST_WIDTH_X36 : SBST_WIDTH_X18; // R11
    wire [SBST_ID_LEN-1:0] id_value = {REVISION, id_depth, id_width, SBST_ID_RSVD_VAL, MANUF_CODE,
        SBST_ID_PRESENT}; // R9 R12 R13

    // Instruction register.
    logic [SBST_IR_LEN-1:0] ir_shift_reg; // R8
    logic [SBST_IR_LEN-1:0] ir_reg;
    always_ff @(posedge tck) begin
        if (tap_rst || state_reg == SBST_TLR) begin
            ir_reg <= SBST_IR_RESET; // R18
            ir_shift_reg <= SBST_IR_CAPTURE;
        end else begin
            if (state_reg == SBST_CAP_IR) begin
                ir_shift_reg <= SBST_IR_CAPTURE;
            end else if (state_reg == SBST_SH_IR) begin
                ir_shift_reg <= {scan_in.ser_in, ir_shift_reg[SBST_IR_LEN-1:1]}; // R19
            end
            if (state_reg == SBST_UP_IR) begin
                ir_reg <= ir_shift_reg; // R19
            end
        end
    end

    // Instruction decode; reserved codes fall back to bypass.
    wire sel_bound = ir_reg == SBST_OP_CAPTURE_HIZ || ir_reg == SBST_OP_SAMPLE_HIZ
        || ir_reg == SBST_OP_SAMPLE; // R1 R4 R5
    wire sel_ident = ir_reg == SBST_OP_IDENT; // R2
    wire sel_bypass = !sel_bound && !sel_ident; // R6 R7
    wire want_hiz = ir_reg == SBST_OP_CAPTURE_HIZ || ir_reg == SBST_OP_SAMPLE_HIZ; // R1 R3 R4 R5

    // Data registers.
    logic [SBST_ID_LEN-1:0] id_reg;
    logic byp_reg;
    logic [CHAIN_LEN-1:0] bnd_reg;
    wire cap_dr = state_reg == SBST_CAP_DR;
    wire sh_dr = state_reg == SBST_SH_DR;

    always_ff @(posedge tck) begin
        if (tap_rst) begin
            id_reg <= '0;
            byp_reg <= SBST_BYPASS_CAPTURE;
            bnd_reg <= '0;
        end else begin
            if (cap_dr && sel_ident) begin
                id_reg <= id_value; // R2
            end else if (sh_dr && sel_ident) begin
                id_reg <= {scan_in.ser_in, id_reg[SBST_ID_LEN-1:1]}; // R15
            end
            if (cap_dr && sel_bypass) begin
                byp_reg <= SBST_BYPASS_CAPTURE; // R23
            end else if (sh_dr && sel_bypass) begin
                byp_reg <= scan_in.ser_in; // R6
            end
            // Update-DR has no branch here, so it leaves the chain as a pause would.
            if (cap_dr && sel_bound) begin
                bnd_reg <= ring_sync_reg; // R1 R4 R5 R21 R22
            end else if (sh_dr && sel_bound) begin
                bnd_reg <= {scan_in.ser_in, bnd_reg[CHAIN_LEN-1:1]}; // R20
            end
        end
    end

    // Output stage on the falling edge gives the controller half a period of hold.
    wire ser_bit = state_reg == SBST_SH_IR ? ir_shift_reg[0]
        : sel_ident ? id_reg[0] : sel_bound ? bnd_reg[0] : byp_reg;
    wire ser_drive = state_reg == SBST_SH_IR || sh_dr;
    logic tdo_reg;
    logic tdo_oe_reg;
    always_ff @(negedge tck) begin
        if (tap_rst) begin
            tdo_reg <= 1'b0;
            tdo_oe_reg <= 1'b0;
        end else begin
            tdo_reg <= ser_bit; // R16
            tdo_oe_reg <= ser_drive; // R16
        end
    end
    assign scan_out = '{ser_out: tdo_reg, ser_out_oe: tdo_oe_reg};

    // Isolation request registered in the scan domain, then synchronised into the system domain.
    logic hiz_tck_reg;
    always_ff @(posedge tck) begin
        if (tap_rst) begin
            hiz_tck_reg <= 1'b0;
        end else begin
            hiz_tck_reg <= want_hiz; // R1 R4
        end
    end

    logic hiz_meta_reg;
    logic hiz_sys_reg;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            hiz_meta_reg <= 1'b0;
            hiz_sys_reg <= 1'b0;
        end else begin
            hiz_meta_reg <= hiz_tck_reg;
            hiz_sys_reg <= hiz_meta_reg; // R3
        end
    end
    assign sram_out_hiz = hiz_sys_reg;

    // Checks in the scan domain, except the isolation cover on the system clock.
    property p_tlr_ident;
        @(posedge tck) disable iff (tap_rst)
        state_reg == SBST_TLR |=> ir_reg == SBST_OP_IDENT;
    endproperty
    a_tlr_ident: assert property (p_tlr_ident) else $error("Reset state did not select identification."); // R18

    property p_update_ir;
        @(posedge tck) disable iff (tap_rst)
        state_reg == SBST_UP_IR |=> ir_reg == $past(ir_shift_reg);
    endproperty
    a_update_ir: assert property (p_update_ir) else $error("Instruction not applied at update."); // R19

    property p_ir_hold;
        @(posedge tck) disable iff (tap_rst)
        state_reg != SBST_UP_IR && state_reg != SBST_TLR |=> $stable(ir_reg);
    endproperty
    a_ir_hold: assert property (p_ir_hold) else $error("Instruction changed outside update."); // R19

    property p_hiz_capture;
        @(posedge tck) disable iff (tap_rst)
        ir_reg == SBST_OP_CAPTURE_HIZ ##1 ir_reg == SBST_OP_CAPTURE_HIZ |-> hiz_tck_reg;
    endproperty
    a_hiz_capture: assert property (p_hiz_capture) else $error("Outputs not isolated for code 000."); // R1

    property p_hiz_sample_z;
        @(posedge tck) disable iff (tap_rst)
        ir_reg == SBST_OP_SAMPLE_HIZ ##1 ir_reg == SBST_OP_SAMPLE_HIZ |-> hiz_tck_reg;
    endproperty
    a_hiz_sample_z: assert property (p_hiz_sample_z) else $error("Outputs not isolated for code 010."); // R4

    property p_no_hiz;
        @(posedge tck) disable iff (tap_rst)
        (ir_reg == SBST_OP_SAMPLE || ir_reg == SBST_OP_IDENT || ir_reg == SBST_OP_BYPASS)[*2] |-> !hiz_tck_reg;
    endproperty
    a_no_hiz: assert property (p_no_hiz) else $error("Outputs isolated by a transparent instruction."); // R3

    property p_ident_capture;
        @(posedge tck) disable iff (tap_rst)
        cap_dr && sel_ident |=> id_reg[0] == SBST_ID_PRESENT
            && id_reg[SBST_ID_DEPTH_LSB +: 5] == (WIDE_ORG ? SBST_DEPTH_512K : SBST_DEPTH_1M)
            && id_reg[SBST_ID_WIDTH_LSB +: 5] == (WIDE_ORG ? SBST_WIDTH_X36 : SBST_WIDTH_X18)
            && id_reg[SBST_ID_REV_LSB +: 4] == REVISION && id_reg[SBST_ID_MANUF_LSB +: 11] == MANUF_CODE;
    endproperty
    a_ident_capture: assert property (p_ident_capture) else $error("Identification capture wrong."); // R2

    property p_bypass_zero;
        @(posedge tck) disable iff (tap_rst)
        cap_dr && sel_bypass |=> byp_reg == 1'b0;
    endproperty
    a_bypass_zero: assert property (p_bypass_zero) else $error("Bypass did not capture zero."); // R23

    property p_chain_shift;
        @(posedge tck) disable iff (tap_rst)
        sh_dr && sel_bound |=> bnd_reg[CHAIN_LEN-1] == $past(scan_in.ser_in)
            && bnd_reg[CHAIN_LEN-2:0] == $past(bnd_reg[CHAIN_LEN-1:1]);
    endproperty
    a_chain_shift: assert property (p_chain_shift) else $error("Boundary chain shifted wrong way."); // R20

    property p_update_dr_pause;
        @(posedge tck) disable iff (tap_rst)
        state_reg == SBST_UP_DR |=> $stable(bnd_reg) && $stable(hiz_tck_reg);
    endproperty
    a_update_dr_pause: assert property (p_update_dr_pause) else $error("Update-DR disturbed the chain."); // R21

    property p_tms_walk;
        @(posedge tck) disable iff (tap_rst)
        state_reg == SBST_SEL_DR && !scan_in.mode_sel |=> state_reg == SBST_CAP_DR;
    endproperty
    a_tms_walk: assert property (p_tms_walk) else $error("Mode select not followed."); // R14

    property p_bypass_shift;
        @(posedge tck) disable iff (tap_rst)
        sh_dr && sel_bypass |=> byp_reg == $past(scan_in.ser_in);
    endproperty
    a_bypass_shift: assert property (p_bypass_shift) else $error("Bypass did not pass the serial bit."); // R6

    property p_ir_capture;
        @(posedge tck) disable iff (tap_rst)
        state_reg == SBST_CAP_IR |=> ir_shift_reg == SBST_IR_CAPTURE;
    endproperty
    a_ir_capture: assert property (p_ir_capture) else $error("Instruction capture value wrong."); // R19

    property p_ident_shift;
        @(posedge tck) disable iff (tap_rst)
        sh_dr && sel_ident |=> id_reg[SBST_ID_LEN-1] == $past(scan_in.ser_in);
    endproperty
    a_ident_shift: assert property (p_ident_shift) else $error("Identification shift lost the serial bit."); // R15

    property p_ring_capture;
        @(posedge tck) disable iff (tap_rst)
        cap_dr && sel_bound |=> bnd_reg == $past(ring_sync_reg);
    endproperty
    a_ring_capture: assert property (p_ring_capture) else $error("Pin ring not captured."); // R1

    c_ident_shift: cover property (@(posedge tck) disable iff (tap_rst) sh_dr && sel_ident);
    c_ir_load: cover property (@(posedge tck) disable iff (tap_rst) state_reg == SBST_UP_IR ##1 sel_bound);
    c_bypass_shift: cover property (@(posedge tck) disable iff (tap_rst) sh_dr && sel_bypass);
    c_hiz_out: cover property (@(posedge clk_sys) disable iff (srst) sram_out_hiz);
    c_tlr_exit: cover property (@(posedge tck) disable iff (tap_rst) state_reg == SBST_TLR ##1 state_reg == SBST_RTI);

endmodule

/* test/sbst_ctrl_model.sv */
/*
 * Behavioural boundary-scan test controller that drives the scan port one clock at a time.
 * Assumes the bench calls step and that the scan clock stands low between steps.
 */
`timescale 1ns/1ps
module sbst_ctrl_model
    import sbst_pkg::*;
(
    // Scan link.
    output logic tck,
    output sbst_scan_in_s scan_in,
    input wire sbst_scan_out_s scan_out
);
    initial begin
        tck = 1'b0;
        scan_in = '{mode_sel: 1'b1, ser_in: 1'b0};
    end

    // Inputs change while the clock is low, so the rising edge sees settled values.
    task automatic step(input logic tms, input logic tdi, output logic tdo, output logic oe);
        scan_in.mode_sel = tms;
        scan_in.ser_in = tdi;
        // The bench period of 64 ns is shorter than a real controller uses; the logic has no timing of its own.
        #32;
        tdo = scan_out.ser_out;
        oe = scan_out.ser_out_oe;
        tck = 1'b1;
        #16;
        // After the hold time the data line no longer shows the last bit.
        scan_in.ser_in = ~tdi;
        #16;
        tck = 1'b0;
    endtask
endmodule

/* test/test_sram_boundary_scan_tap.sv */
/*
 * Self-checking bench for the scan port: identification, bypass, boundary capture and isolation.
 * Assumes the design uses the wide organisation and the controller model for the scan link.
 */
`timescale 1ns/1ps
`define CHECK(got, exp) compare(70'(got), 70'(exp))
module test_sram_boundary_scan_tap;
    import sbst_pkg::*;
    // Arbitrary values, chosen to catch a hard-wired field.
    localparam logic [10:0] MANUF = 11'h2A3;
    localparam logic [3:0] REV = 4'h5;
    logic clk_sys;
    logic srst;
    logic sram_out_hiz;
    logic tck;
    sbst_scan_in_s scan_in;
    sbst_scan_out_s scan_out;
    logic [69:0] ring_pins;
    int bad_count = 0;
    int check_count = 0;
    logic t;
    logic o;

    sbst_tap #(.WIDE_ORG(1'b1), .REVISION(REV), .MANUF_CODE(MANUF)) sbst_tap_inst (.clk_sys(clk_sys),
        .srst(srst), .sram_out_hiz(sram_out_hiz), .tck(tck), .scan_in(scan_in), .scan_out(scan_out),
        .ring_pins(ring_pins));
    sbst_ctrl_model sbst_ctrl_model_inst (.tck(tck), .scan_in(scan_in), .scan_out(scan_out));

    task automatic compare(input logic [69:0] got, input logic [69:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Walks from idle through a shift of n bits and back to idle; bit 0 leaves first.
    task automatic scan(input logic ir, input logic [69:0] din, input int n, output logic [69:0] dout);
        dout = '0;
        sbst_ctrl_model_inst.step(1'b1, 1'b0, t, o);
        if (ir) sbst_ctrl_model_inst.step(1'b1, 1'b0, t, o);
        sbst_ctrl_model_inst.step(1'b0, 1'b0, t, o);
        sbst_ctrl_model_inst.step(1'b0, 1'b0, t, o);
        for (int i = 0; i < n; i++) begin
            sbst_ctrl_model_inst.step(i == n - 1, din[i], t, o);
            dout[i] = t;
            `CHECK(o, 1'b1);
        end
        sbst_ctrl_model_inst.step(1'b1, 1'b0, t, o);
        sbst_ctrl_model_inst.step(1'b0, 1'b0, t, o);
    endtask

    task automatic load_ir(input logic [2:0] code, input logic hiz);
        logic [69:0] d;
        scan(1'b1, {67'h0, code}, 3, d);
        `CHECK(d[2:0], SBST_IR_CAPTURE);
        // The isolation flag only registers the new instruction on a further scan clock edge.
        sbst_ctrl_model_inst.step(1'b0, 1'b0, t, o);
        repeat (8) @(posedge clk_sys);
        `CHECK(sram_out_hiz, hiz);
    endtask

    task automatic check_id();
        logic [69:0] d;
        scan(1'b0, 70'h0, 32, d);
        `CHECK(d[31:0], {REV, SBST_DEPTH_512K, SBST_WIDTH_X36, SBST_ID_RSVD_VAL, MANUF, SBST_ID_PRESENT});
    endtask

    task automatic test_bypass();
        logic [69:0] d;
        load_ir(SBST_OP_BYPASS, 1'b0);
        scan(1'b0, 70'hA5, 9, d);
        `CHECK(d[8:0], 9'h14A);
    endtask

    // Only defined codes are loaded.
    task automatic test_boundary(input logic [2:0] code, input logic hiz, input logic [69:0] val);
        logic [69:0] d;
        @(posedge clk_sys);
        ring_pins <= val;
        load_ir(code, hiz);
        scan(1'b0, ~val, 70, d);
        `CHECK(d, val);
        scan(1'b0, 70'h0, 70, d);
        `CHECK(d, val);
        repeat (8) @(posedge clk_sys);
        `CHECK(sram_out_hiz, hiz);
    endtask

    task automatic test_tlr();
        load_ir(SBST_OP_CAPTURE_HIZ, 1'b1);
        repeat (5) sbst_ctrl_model_inst.step(1'b1, 1'b0, t, o);
        sbst_ctrl_model_inst.step(1'b0, 1'b0, t, o);
        repeat (8) @(posedge clk_sys);
        `CHECK(sram_out_hiz, 1'b0);
        check_id();
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    initial begin
        #200000;
        bad_count++;
        end_of_test();
    end

    initial begin
        srst = 1'b1;
        ring_pins = 70'h0;
        // The scan clock must run while reset is held so the link domain sees it.
        repeat (16) @(posedge clk_sys);
        repeat (4) sbst_ctrl_model_inst.step(1'b1, 1'b0, t, o);
        @(posedge clk_sys);
        srst <= 1'b0;
        repeat (4) sbst_ctrl_model_inst.step(1'b1, 1'b0, t, o);
        sbst_ctrl_model_inst.step(1'b0, 1'b0, t, o);
        `CHECK(sram_out_hiz, 1'b0);
        check_id();
        test_bypass();
        test_boundary(SBST_OP_CAPTURE_HIZ, 1'b1, 70'h2A_5555_0F0F_1234_ABCD);
        test_boundary(SBST_OP_SAMPLE_HIZ, 1'b1, 70'h15_AAAA_F0F0_EDCB_5432);
        test_boundary(SBST_OP_SAMPLE, 1'b0, 70'h3C_0001_8000_0000_0003);
        load_ir(SBST_OP_IDENT, 1'b0);
        check_id();
        test_tlr();
        end_of_test();
    end
endmodule
